/* design/hmb_regs.sv */
// Host miscellaneous and buffer length/status register group
// What this block does
// RULE1: Read code 27 returns a read-only identifier, product byte high and revision byte low.
// RULE2: A 16-bit scratch register is written by code A8, read by code 28, and resets to zero.
// RULE3: Software writes F6 with code A9 to reset the controller, which then clears all registers.
// RULE4: The software reset touches register state only, never the buffer memory contents.
// RULE5: Code AA writes and 2A reads the isochronous length, which sizes both iso buffers alike.
// RULE6: Software keeps ack length plus twice the iso length within 1000H bytes of buffer RAM.
// RULE7: Code AB writes and 2B reads the 16-bit acknowledged list buffer length.
// RULE8: Code 2C reads a read-only buffer status whose bits 15 to 6 read as zero.
// RULE9: Status bits 5, 4, 3 show the ack, second iso and first iso buffers have been read.
// RULE10: Status bits 2, 1, 0 show the ack, second iso and first iso buffers are full.
// RULE11: Non-key writes to the reset code and writes aimed at read-only registers do nothing.
// RULE12: After any reset both lengths and the status read zero until reprogrammed or set.
module hmb_regs #(
    parameter logic [7:0] PRODUCT_CODE = hmb_pkg::PRODUCT_CODE_DEF,
    parameter logic [7:0] REVISION_CODE = hmb_pkg::REVISION_CODE_DEF
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Command access from the processor bus logic (same clock)
    input wire logic [7:0] cmd,
    input wire logic rd,
    input wire logic wr,
    input wire logic [15:0] wdata,
    // Read answer
    output logic [15:0] rdata,
    output logic rvalid,
    // Buffer events from the transfer engine (same clock, one-cycle pulses)
    input wire logic [2:0] full_set,
    input wire logic [2:0] full_clr,
    input wire logic [2:0] done_set,
    input wire logic [2:0] done_clr,
    // Register values to the buffer logic
    output logic [15:0] iso_length_value,
    output logic [15:0] ack_length_value,
    output logic len_overflow,
    output logic soft_reset_pulse
);
    typedef struct packed {
        logic [15:0] scratch;
        logic [15:0] iso_len;
        logic [15:0] ack_len;
        logic [15:0] rdata;
        logic rvalid;
        logic soft_rst;
        logic overflow;
    } hmb_regs_state_t;

    hmb_regs_state_t st_reg;
    hmb_regs_state_t st_next;

    logic rd_id;
    logic rd_scratch;
    logic rd_iso;
    logic rd_ack;
    logic rd_status;
    logic wr_scratch;
    logic wr_iso;
    logic wr_ack;
    logic wr_reset;
    logic rd_known;
    logic key_hit;
    logic [5:0] flags;
    logic [2:0] soft_vec;
    logic [16:0] total_bytes;

    hmb_cmd_decode u_dec (
        .cmd(cmd),
        .rd(rd),
        .wr(wr),
        .rd_id(rd_id),
        .rd_scratch(rd_scratch),
        .rd_iso(rd_iso),
        .rd_ack(rd_ack),
        .rd_status(rd_status),
        .wr_scratch(wr_scratch),
        .wr_iso(wr_iso),
        .wr_ack(wr_ack),
        .wr_reset(wr_reset),
        .rd_known(rd_known)
    );

    // Only the exact key triggers; any other value is dropped
    assign key_hit = wr_reset && (wdata == hmb_pkg::SW_RESET_KEY); // see RULE3 see RULE11
    assign soft_vec = {3{st_reg.soft_rst}};

    // Bits 0..2 full, 3..5 done; each in order first iso, second iso, ack
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            hmb_flag u_full (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .clk_en(clk_en),
                .soft_clr(soft_vec[gi]),
                .set_evt(full_set[gi]),
                .clr_evt(full_clr[gi]),
                .flag(flags[hmb_pkg::ST_FIRST_FULL + gi])
            ); // see RULE10
            hmb_flag u_done (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .clk_en(clk_en),
                .soft_clr(soft_vec[gi]),
                .set_evt(done_set[gi]),
                .clr_evt(done_clr[gi]),
                .flag(flags[hmb_pkg::ST_FIRST_DONE + gi])
            ); // see RULE9
        end
    endgenerate

    // Budget check only flags misuse; the lengths are still taken as written
    assign total_bytes = {1'b0, st_reg.ack_len} + {st_reg.iso_len, 1'b0}; // see RULE6

    always_comb begin
        st_next = st_reg;
        st_next.rvalid = rd_known;
        st_next.soft_rst = key_hit;
        st_next.overflow = (total_bytes > hmb_pkg::BUF_RAM_BYTES) || st_reg.iso_len[15];
        if (rd_id) begin
            st_next.rdata = {PRODUCT_CODE, REVISION_CODE}; // see RULE1
        end else if (rd_scratch) begin
            st_next.rdata = st_reg.scratch; // see RULE2
        end else if (rd_iso) begin
            st_next.rdata = st_reg.iso_len; // see RULE5
        end else if (rd_ack) begin
            st_next.rdata = st_reg.ack_len; // see RULE7
        end else if (rd_status) begin
            st_next.rdata = {10'h000, flags}; // see RULE8
        end
        // Registers clear the cycle after the key; buffer RAM lives elsewhere.
        // The clear comes first so a write taken in that same cycle still lands.
        if (st_reg.soft_rst) begin
            st_next.scratch = hmb_pkg::SCRATCH_RST; // see RULE3 see RULE4
            st_next.iso_len = hmb_pkg::LEN_RST; // see RULE12
            st_next.ack_len = hmb_pkg::LEN_RST; // see RULE12
            st_next.overflow = 1'b0;
        end
        // Writes to read-only codes decode to nothing and fall through
        if (wr_scratch) begin
            st_next.scratch = wdata; // see RULE2
        end
        if (wr_iso) begin
            st_next.iso_len = wdata; // see RULE5
        end
        if (wr_ack) begin
            st_next.ack_len = wdata; // see RULE7
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign rvalid = st_reg.rvalid;
    assign iso_length_value = st_reg.iso_len;
    assign ack_length_value = st_reg.ack_len;
    assign len_overflow = st_reg.overflow;
    assign soft_reset_pulse = st_reg.soft_rst;
endmodule // hmb_regs

/* design/hmb_pkg.sv */
// Shared constants for the host miscellaneous and buffer control register group
package hmb_pkg;
    localparam int DATA_W = 16;
    localparam int CMD_W = 8;
    // Command codes
    localparam logic [7:0] CMD_RD_CHIP_ID = 8'h27;
    localparam logic [7:0] CMD_RD_SCRATCH = 8'h28;
    localparam logic [7:0] CMD_WR_SCRATCH = 8'hA8;
    localparam logic [7:0] CMD_WR_SW_RESET = 8'hA9;
    localparam logic [7:0] CMD_RD_ISO_LEN = 8'h2A;
    localparam logic [7:0] CMD_WR_ISO_LEN = 8'hAA;
    localparam logic [7:0] CMD_RD_ACK_LEN = 8'h2B;
    localparam logic [7:0] CMD_WR_ACK_LEN = 8'hAB;
    localparam logic [7:0] CMD_RD_BUF_STATUS = 8'h2C;
    // Reset key and values
    localparam logic [15:0] SW_RESET_KEY = 16'h00F6;
    localparam logic [15:0] SCRATCH_RST = 16'h0000;
    localparam logic [15:0] LEN_RST = 16'h0000;
    // Arbitrary identifier values, not those of any real part
    localparam logic [7:0] PRODUCT_CODE_DEF = 8'hA5;
    localparam logic [7:0] REVISION_CODE_DEF = 8'h01;
    // Status field positions
    localparam int ST_FIRST_FULL = 0;
    localparam int ST_SECOND_FULL = 1;
    localparam int ST_ACK_FULL = 2;
    localparam int ST_FIRST_DONE = 3;
    localparam int ST_SECOND_DONE = 4;
    localparam int ST_ACK_DONE = 5;
    localparam int ST_FLAGS = 6;
    // Total buffer RAM size in bytes
    localparam logic [16:0] BUF_RAM_BYTES = 17'h01000;
endpackage : hmb_pkg

/* design/hmb_flag.sv */
// One buffer status flag: set by an event, cleared by an event, set wins
module hmb_flag (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic soft_clr,
    // Events
    input wire logic set_evt,
    input wire logic clr_evt,
    // State
    output logic flag
);
    typedef struct packed {
        logic flag;
    } hmb_flag_state_t;

    hmb_flag_state_t st_reg;
    hmb_flag_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (soft_clr) begin
            st_next.flag = 1'b0; // see RULE12
        end
        if (clr_evt) begin
            st_next.flag = 1'b0;
        end
        // A set arriving with a clear is not lost
        if (set_evt) begin
            st_next.flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.flag;
endmodule // hmb_flag

/* design/hmb_cmd_decode.sv */
// Decodes a command code into register select strobes
module hmb_cmd_decode (
    // Command
    input wire logic [7:0] cmd,
    input wire logic rd,
    input wire logic wr,
    // Strobes
    output logic rd_id,
    output logic rd_scratch,
    output logic rd_iso,
    output logic rd_ack,
    output logic rd_status,
    output logic wr_scratch,
    output logic wr_iso,
    output logic wr_ack,
    output logic wr_reset,
    output logic rd_known
);
    always_comb begin
        rd_id = rd && (cmd == hmb_pkg::CMD_RD_CHIP_ID); // see RULE1
        rd_scratch = rd && (cmd == hmb_pkg::CMD_RD_SCRATCH); // see RULE2
        rd_iso = rd && (cmd == hmb_pkg::CMD_RD_ISO_LEN); // see RULE5
        rd_ack = rd && (cmd == hmb_pkg::CMD_RD_ACK_LEN); // see RULE7
        rd_status = rd && (cmd == hmb_pkg::CMD_RD_BUF_STATUS); // see RULE8
        wr_scratch = wr && (cmd == hmb_pkg::CMD_WR_SCRATCH); // see RULE2
        wr_iso = wr && (cmd == hmb_pkg::CMD_WR_ISO_LEN); // see RULE5
        wr_ack = wr && (cmd == hmb_pkg::CMD_WR_ACK_LEN); // see RULE7
        wr_reset = wr && (cmd == hmb_pkg::CMD_WR_SW_RESET); // see RULE3
        rd_known = rd_id | rd_scratch | rd_iso | rd_ack | rd_status;
    end
endmodule // hmb_cmd_decode

/* verification/hmb_regs_checker.sv */
// Port assertions for the register group
module hmb_regs_checker #(
    parameter logic [7:0] PRODUCT_CODE = hmb_pkg::PRODUCT_CODE_DEF,
    parameter logic [7:0] REVISION_CODE = hmb_pkg::REVISION_CODE_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Command
    input wire logic [7:0] cmd,
    input wire logic rd,
    input wire logic wr,
    input wire logic [15:0] wdata,
    // Outputs
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic [15:0] iso_length_value,
    input wire logic [15:0] ack_length_value,
    input wire logic len_overflow,
    input wire logic soft_reset_pulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic go_rd;
    logic go_wr;
    logic key;
    logic [17:0] need;
    assign go_rd = clk_en && rd;
    assign go_wr = clk_en && wr;
    assign key = go_wr && cmd == 8'hA9 && wdata == 16'h00F6;
    assign need = {2'b00, ack_length_value} + {1'b0, iso_length_value, 1'b0};
    id_read_a: assert property (go_rd && cmd == 8'h27 |=> rvalid &&
        rdata == {PRODUCT_CODE, REVISION_CODE}) else $error("identifier read wrong");
    status_rsv_a: assert property (go_rd && cmd == 8'h2C |=> rdata[15:6] == 10'h000)
        else $error("reserved status bits set");
    iso_write_a: assert property (go_wr && cmd == 8'hAA |=> iso_length_value == $past(wdata))
        else $error("iso length not written");
    ack_write_a: assert property (go_wr && cmd == 8'hAB |=> ack_length_value == $past(wdata))
        else $error("ack length not written");
    key_pulse_a: assert property (key |=> soft_reset_pulse) else $error("no reset pulse");
    pulse_cause_a: assert property ($rose(soft_reset_pulse) |-> $past(key))
        else $error("reset pulse without key");
    soft_clear_a: assert property (soft_reset_pulse && clk_en && !wr |=>
        iso_length_value == 16'h0000 && ack_length_value == 16'h0000) else $error("no clear");
    ovf_track_a: assert property (clk_en && !soft_reset_pulse ##1 clk_en |->
        len_overflow == ($past(need) > 18'h01000)) else $error("overflow flag wrong");
    cover property (soft_reset_pulse);
    cover property (len_overflow);
    cover property (go_rd && cmd == 8'h2C);
endmodule // hmb_regs_checker

bind hmb_regs hmb_regs_checker #(.PRODUCT_CODE(PRODUCT_CODE), .REVISION_CODE(REVISION_CODE))
    i_hmb_regs_checker (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .cmd(cmd), .rd(rd),
    .wr(wr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .iso_length_value(iso_length_value),
    .ack_length_value(ack_length_value), .len_overflow(len_overflow),
    .soft_reset_pulse(soft_reset_pulse));

/* verification/hmb_host_model.sv */
// Processor-side model issuing one command access at a time
module hmb_host_model (
    // Clock
    input wire logic ref_clk,
    // Command
    output logic [7:0] cmd,
    output logic rd,
    output logic wr,
    output logic [15:0] wdata,
    // Answer
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 16'h0000;
    end
    // Caller supplies the key and lengths; nothing here checks the key or the budget
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
        output logic v, output logic [15:0] q);
        @(posedge ref_clk);
        cmd <= c;
        rd <= !w;
        wr <= w;
        wdata <= d;
        @(posedge ref_clk);
        rd <= 1'b0;
        wr <= 1'b0;
        // Stale data must not pass for a held value
        wdata <= ~d;
        #1;
        v = rvalid;
        q = rdata;
    endtask
endmodule // hmb_host_model

/* verification/hmb_regs_tb.sv */
// Self-checking bench for the register group
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module hmb_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic en = 1'b1;
    logic [2:0] fs = 3'h0, fc = 3'h0, ds = 3'h0, dc = 3'h0;
    logic [7:0] cmd;
    logic rd, wr, rvalid, len_overflow, soft_reset_pulse, v;
    logic [15:0] wdata, rdata, iso_len, ack_len, q;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] zc[4] = '{8'h28, 8'h2A, 8'h2B, 8'h2C};
    logic [41:0] rows[18] = '{{1'b0, 8'h27, 16'h0, 1'b1, 16'hA501},
        {1'b0, 8'h28, 16'h0, 1'b1, 16'h0}, {1'b0, 8'h2A, 16'h0, 1'b1, 16'h0},
        {1'b0, 8'h2B, 16'h0, 1'b1, 16'h0}, {1'b0, 8'h2C, 16'h0, 1'b1, 16'h0},
        {1'b1, 8'hA8, 16'h1234, 17'h0}, {1'b0, 8'h28, 16'h0, 1'b1, 16'h1234},
        {1'b1, 8'hAA, 16'h0400, 17'h0}, {1'b0, 8'h2A, 16'h0, 1'b1, 16'h0400},
        {1'b1, 8'hAB, 16'h0800, 17'h0}, {1'b0, 8'h2B, 16'h0, 1'b1, 16'h0800},
        {1'b1, 8'h27, 16'hFFFF, 17'h0}, {1'b0, 8'h27, 16'h0, 1'b1, 16'hA501},
        {1'b1, 8'hA9, 16'h00F5, 17'h0}, {1'b0, 8'h28, 16'h0, 1'b1, 16'h1234},
        {1'b1, 8'h2C, 16'hFFFF, 17'h0}, {1'b0, 8'h2C, 16'h0, 1'b1, 16'h0},
        {1'b0, 8'h40, 16'h0, 17'h0}};
    always #5 ref_clk = ~ref_clk;
    hmb_regs i_hmb_regs (.ref_clk(ref_clk), .nrst(nrst), .clk_en(en), .cmd(cmd), .rd(rd),
        .wr(wr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .full_set(fs), .full_clr(fc),
        .done_set(ds), .done_clr(dc), .iso_length_value(iso_len), .ack_length_value(ack_len),
        .len_overflow(len_overflow), .soft_reset_pulse(soft_reset_pulse));
    hmb_host_model i_hmb_host_model (.ref_clk(ref_clk), .cmd(cmd), .rd(rd), .wr(wr),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic pulse(input logic [2:0] a, b, c, d);
        @(posedge ref_clk);
        {fs, fc, ds, dc} <= {a, b, c, d};
        @(posedge ref_clk);
        {fs, fc, ds, dc} <= 12'h000;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            i_hmb_host_model.acc(rows[i][41], rows[i][40:33], rows[i][32:17], v, q);
            `CHK(v, rows[i][16])
            if (rows[i][16]) `CHK(q, rows[i][15:0])
        end
        $display("table done");
        `CHK(len_overflow, 1'b0)
        i_hmb_host_model.acc(1'b1, 8'hAA, 16'h0401, v, q);
        repeat (2) @(posedge ref_clk);
        `CHK(len_overflow, 1'b1)
        `CHK(iso_len, 16'h0401)
        $display("overflow done");
        pulse(3'b101, 3'b000, 3'b010, 3'b000);
        i_hmb_host_model.acc(1'b0, 8'h2C, 16'h0, v, q);
        `CHK(q, 16'h0015)
        pulse(3'b010, 3'b011, 3'b000, 3'b010);
        i_hmb_host_model.acc(1'b0, 8'h2C, 16'h0, v, q);
        `CHK(q, 16'h0006)
        $display("flags done");
        i_hmb_host_model.acc(1'b1, 8'hA9, 16'h00F6, v, q);
        `CHK(soft_reset_pulse, 1'b1)
        foreach (zc[i]) begin
            i_hmb_host_model.acc(1'b0, zc[i], 16'h0, v, q);
            `CHK(q, 16'h0000)
        end
        i_hmb_host_model.acc(1'b0, 8'h27, 16'h0, v, q);
        `CHK(q, 16'hA501)
        `CHK(len_overflow, 1'b0)
        $display("soft reset done");
        // With the enable low nothing may be taken or answered
        @(posedge ref_clk);
        en <= 1'b0;
        i_hmb_host_model.acc(1'b1, 8'hA8, 16'hBEEF, v, q);
        i_hmb_host_model.acc(1'b0, 8'h27, 16'h0, v, q);
        `CHK(v, 1'b0)
        @(posedge ref_clk);
        en <= 1'b1;
        i_hmb_host_model.acc(1'b0, 8'h28, 16'h0, v, q);
        `CHK(q, 16'h0000)
        $display("enable done");
        i_hmb_host_model.acc(1'b1, 8'hAB, 16'h0123, v, q);
        `CHK(ack_len, 16'h0123)
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK(ack_len, 16'h0000)
        `CHK(soft_reset_pulse, 1'b0)
        nrst <= 1'b1;
        i_hmb_host_model.acc(1'b0, 8'h2B, 16'h0, v, q);
        `CHK(q, 16'h0000)
        i_hmb_host_model.acc(1'b0, 8'h27, 16'h0, v, q);
        `CHK(q, 16'hA501)
        $display("hard reset done");
        conclude();
    end
endmodule // hmb_regs_tb
